/* File: design/acq_sequencer.sv */
// Purpose: conversion sequencer, input filters and sample buffer
// Assumes: external pins synchronous to clk; converter answers each start
// Notes: registers on a plain strobe port, read data one cycle later
`timescale 1ns/100ps
`default_nettype none
module acq_sequencer
    import acq_pkg::*;
#(
    parameter int BUF_DEPTH_P = BUF_DEPTH,
    parameter int STAGE_DEPTH_P = STAGE_DEPTH
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic ext_start,
    input wire logic ext_stop,
    input wire logic ext_clk,
    output logic conv_start,
    output logic [CH_W-1:0] conv_chan,
    input wire logic conv_valid,
    output logic conv_ready,
    input wire logic [SAMPLE_W-1:0] conv_data,
    output logic seq_busy
);
    localparam int BUF_AW = $clog2(BUF_DEPTH_P);
    localparam logic [BUF_AW:0] BUF_FULL = (BUF_AW+1)'(BUF_DEPTH_P);
    localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILT_CYC - 1);

    typedef struct packed {
        seq_state_t st;
        logic [CH_W-1:0] chan;
        logic conv_start;
        logic [CNT_W-1:0] tcnt;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] target;
        logic [CNT_W-1:0] scnt;
        logic [CFG_W-1:0] cfg;
        logic [NUM_IN-1:0] filt;
        logic [NUM_IN-1:0] fprev;
        logic [NUM_IN-1:0][FILT_W-1:0] fcnt;
        logic done;
        logic overrun;
        logic wrapped;
        logic [BUF_AW-1:0] wptr;
        logic [BUF_AW-1:0] rptr;
        logic [BUF_AW:0] level;
        logic [DATA_W-1:0] rdata;
    } acq_state_t;

    localparam acq_state_t S_RST = '{st: ST_IDLE, period: PERIOD_RST,
        target: COUNT_RST, default: '0};

    function automatic logic edge_hit(input logic cur, input logic prev,
                                      input logic fall);
        edge_hit = fall ? (prev & ~cur) : (cur & ~prev);
    endfunction

    acq_state_t s_q, s_d;
    logic [SAMPLE_W-1:0] buf_mem [BUF_DEPTH_P];
    logic [NUM_IN-1:0] raw, ev;
    logic [1:0] stop_src;
    logic ring, wr_ctrl, sw_start, sw_stop, clr_buf, tick_t, pace;
    logic stage_in_valid, stage_in_ready, stage_out_valid, buf_ready;
    logic [SAMPLE_W-1:0] stage_out_data;
    logic buf_push, buf_pop, accept, count_hit, stop_hit;

    // ------------------------------------------------------------
    // staging fifo in the result path
    // ------------------------------------------------------------
    assign stage_in_valid = conv_valid & (s_q.st == ST_CONV);
    assign conv_ready = stage_in_ready & (s_q.st == ST_CONV);
    assign accept = stage_in_valid & stage_in_ready;

    acq_stage_fifo #(
        .WIDTH(SAMPLE_W),
        .DEPTH(STAGE_DEPTH_P)
    ) u_stage (
        .clk(clk),
        .reset(reset),
        .in_valid(stage_in_valid),
        .in_ready(stage_in_ready),
        .in_data(conv_data),
        .out_valid(stage_out_valid),
        .out_ready(buf_ready),
        .out_data(stage_out_data)
    );

    // ------------------------------------------------------------
    // decode and events
    // ------------------------------------------------------------
    assign raw = {ext_clk, ext_stop, ext_start};
    assign ring = s_q.cfg[CFG_RING];
    assign stop_src = s_q.cfg[CFG_STOP_LO +: 2];
    assign wr_ctrl = reg_wr & (reg_addr == REG_CTRL);
    assign sw_start = wr_ctrl & reg_wdata[CTRL_START];
    assign sw_stop = wr_ctrl & reg_wdata[CTRL_STOP];
    assign clr_buf = wr_ctrl & reg_wdata[CTRL_CLEAR];
    // fifo mode full: hold results back so the stage fills and stalls the scan
    assign buf_ready = ring | (s_q.level != BUF_FULL);
    assign buf_push = stage_out_valid & buf_ready;
    assign buf_pop = reg_rd & (reg_addr == REG_DATA) & (s_q.level != '0);
    // period of zero or one paces every cycle
    assign tick_t = ({1'b0, s_q.tcnt} + 1'b1) >= {1'b0, s_q.period};
    assign pace = s_q.cfg[CFG_CLK_EXT] ? ev[IN_CLK] : tick_t;
    assign count_hit = accept & (stop_src == STOP_COUNT)
                     & ((s_q.scnt + 1'b1) >= s_q.target);
    assign stop_hit = sw_stop | ((stop_src == STOP_EXT) & ev[IN_STOP]);

    always_comb begin
        for (int i = 0; i < NUM_IN; i++) begin
            ev[i] = edge_hit(s_q.filt[i], s_q.fprev[i], s_q.cfg[CFG_START_FALL + i]);
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.conv_start = 1'b0;
        s_d.rdata = '0;
        s_d.fprev = s_q.filt;

        for (int i = 0; i < NUM_IN; i++) begin
            if (!s_q.cfg[CFG_FILT_EN]) begin
                s_d.filt[i] = raw[i];
                s_d.fcnt[i] = '0;
            end else if (raw[i] == s_q.filt[i]) begin
                s_d.fcnt[i] = '0;
            end else if (s_q.fcnt[i] == FILT_LAST) begin
                s_d.filt[i] = raw[i];
                s_d.fcnt[i] = '0;
            end else begin
                s_d.fcnt[i] = s_q.fcnt[i] + 1'b1;
            end
        end

        if (reg_wr) begin
            unique case (reg_addr)
                REG_CFG: s_d.cfg = reg_wdata[CFG_W-1:0];
                REG_PERIOD: s_d.period = reg_wdata[CNT_W-1:0];
                REG_COUNT: s_d.target = reg_wdata[CNT_W-1:0];
                REG_STATUS: begin
                    if (reg_wdata[STS_DONE]) s_d.done = 1'b0;
                    if (reg_wdata[STS_OVERRUN]) s_d.overrun = 1'b0;
                    if (reg_wdata[STS_WRAPPED]) s_d.wrapped = 1'b0;
                end
                default: ;
            endcase
        end

        // timer only runs while a sequence is pacing
        if ((s_q.st == ST_RUN) || (s_q.st == ST_CONV)) begin
            s_d.tcnt = tick_t ? '0 : s_q.tcnt + 1'b1;
        end else begin
            s_d.tcnt = '0;
        end

        unique case (s_q.st)
            ST_IDLE: begin
                if (sw_start) begin
                    s_d.scnt = '0;
                    s_d.chan = '0;
                    s_d.st = s_q.cfg[CFG_START_EXT] ? ST_ARMED : ST_RUN;
                end
            end
            ST_ARMED: begin
                if (ev[IN_START]) begin
                    s_d.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (pace) begin
                    s_d.chan = '0;
                    s_d.conv_start = 1'b1;
                    s_d.st = ST_CONV;
                end
            end
            ST_CONV: begin
                // a pace edge during a scan means the scan rate is too high
                if (pace) begin
                    s_d.overrun = 1'b1;
                end
                if (accept) begin
                    s_d.scnt = s_q.scnt + 1'b1;
                    if (count_hit) begin
                        s_d.st = ST_IDLE;
                        s_d.done = 1'b1;
                    end else if (s_q.chan == s_q.cfg[CFG_LAST_LO +: CH_W]) begin
                        s_d.st = ST_RUN;
                    end else begin
                        s_d.chan = s_q.chan + 1'b1;
                        s_d.conv_start = 1'b1;
                    end
                end
            end
        endcase

        if (stop_hit && (s_q.st != ST_IDLE)) begin
            s_d.st = ST_IDLE;
            s_d.conv_start = 1'b0;
        end

        // write pointer advances on its own, no host needed; read pointer on host reads or ring overwrite
        if (buf_push) begin
            s_d.wptr = s_q.wptr + 1'b1;
        end
        if (buf_pop) begin
            s_d.rptr = s_q.rptr + 1'b1;
        end
        if (buf_push && !buf_pop) begin
            if (s_q.level == BUF_FULL) begin
                s_d.rptr = s_q.rptr + 1'b1;
                s_d.wrapped = 1'b1;
            end else begin
                s_d.level = s_q.level + 1'b1;
            end
        end else if (buf_pop && !buf_push) begin
            s_d.level = s_q.level - 1'b1;
        end
        if (clr_buf) begin
            s_d.wptr = '0;
            s_d.rptr = '0;
            s_d.level = '0;
        end

        if (reg_rd) begin
            unique case (reg_addr)
                REG_CFG: s_d.rdata = DATA_W'(s_q.cfg);
                REG_PERIOD: s_d.rdata = DATA_W'(s_q.period);
                REG_COUNT: s_d.rdata = DATA_W'(s_q.target);
                REG_STATUS: begin
                    s_d.rdata[STS_BUSY] = (s_q.st != ST_IDLE);
                    s_d.rdata[STS_ARMED] = (s_q.st == ST_ARMED);
                    s_d.rdata[STS_DONE] = s_q.done;
                    s_d.rdata[STS_OVERRUN] = s_q.overrun;
                    s_d.rdata[STS_WRAPPED] = s_q.wrapped;
                    s_d.rdata[STS_EMPTY] = (s_q.level == '0);
                    s_d.rdata[STS_FULL] = (s_q.level == BUF_FULL);
                end
                REG_DATA: s_d.rdata = buf_pop ? DATA_W'(buf_mem[s_q.rptr]) : '0;
                REG_LEVEL: s_d.rdata = DATA_W'(s_q.level);
                default: s_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk) begin
        if (buf_push) begin
            buf_mem[s_q.wptr] <= stage_out_data;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign conv_start = s_q.conv_start;
    assign conv_chan = s_q.chan;
    assign seq_busy = (s_q.st != ST_IDLE);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_chan_in_scan: assert property (
        conv_start |-> conv_chan <= s_q.cfg[CFG_LAST_LO +: CH_W])
        else $error("channel beyond last scanned channel");

    a_timer_pace: assert property (
        (s_q.st == ST_RUN) && !s_q.cfg[CFG_CLK_EXT] && tick_t && !stop_hit
        |=> conv_start && (s_q.st == ST_CONV))
        else $error("timer tick did not start a scan");

    a_ext_start: assert property (
        (s_q.st == ST_ARMED) && ev[IN_START] && !stop_hit |=> s_q.st == ST_RUN)
        else $error("start edge did not begin sequence");

    a_stop_ends: assert property (
        (s_q.st != ST_IDLE) && stop_hit |=> (s_q.st == ST_IDLE) && !conv_start)
        else $error("stop did not end sequence");

    a_edge_select: assert property (
        ev[IN_STOP] |-> (s_q.filt[IN_STOP] != s_q.fprev[IN_STOP])
        && (s_q.filt[IN_STOP] == !s_q.cfg[CFG_START_FALL + IN_STOP]))
        else $error("stop event on wrong edge");

    a_filter_hold: assert property (
        $past(s_q.cfg[CFG_FILT_EN]) && $changed(s_q.filt[IN_START])
        |-> $past(s_q.fcnt[IN_START]) == FILT_LAST)
        else $error("start input passed filter early");

    a_clk_filter: assert property (
        $past(s_q.cfg[CFG_FILT_EN]) && $changed(s_q.filt[IN_CLK])
        |-> $past(s_q.fcnt[IN_CLK]) == FILT_LAST)
        else $error("clock input passed filter early");

    a_fifo_hold: assert property (
        !ring && (s_q.level == BUF_FULL) |-> !buf_push)
        else $error("fifo mode wrote into full buffer");

    a_ring_wrap: assert property (
        ring && (s_q.level == BUF_FULL) && buf_push && !buf_pop && !clr_buf
        |=> (s_q.level == BUF_FULL) && s_q.wrapped)
        else $error("ring overwrite lost level or flag");

    a_fill_alone: assert property (
        buf_push && !buf_pop && !clr_buf && (s_q.level != BUF_FULL)
        |=> s_q.level == $past(s_q.level) + 1'b1)
        else $error("buffer did not fill without host");

    a_done_flag: assert property (
        count_hit && (s_q.st == ST_CONV) && !stop_hit
        |=> s_q.done && (s_q.st == ST_IDLE))
        else $error("count end did not raise done");
endmodule
`default_nettype wire

/* File: design/acq_stage_fifo.sv */
// Purpose: small staging FIFO between converter results and sample buffer
// Assumes: DEPTH is a power of two
// Notes: in_ready low when full, out_valid low when empty
`timescale 1ns/100ps
`default_nettype none
module acq_stage_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] cnt;
    } fifo_state_t;

    fifo_state_t s_q, s_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push, pop;

    assign in_ready = (s_q.cnt != FULL_CNT);
    assign out_valid = (s_q.cnt != '0);
    assign out_data = mem[s_q.rptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_comb begin
        s_d = s_q;
        if (push) begin
            s_d.wptr = s_q.wptr + 1'b1;
        end
        if (pop) begin
            s_d.rptr = s_q.rptr + 1'b1;
        end
        if (push && !pop) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end else if (pop && !push) begin
            s_d.cnt = s_q.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s_q.wptr] <= in_data;
        end
    end
endmodule
`default_nettype wire

/* File: inc/acq_pkg.sv */
// Purpose: shared constants for the analog input acquisition sequencer
// Assumes: 25 MHz system clock, register port with 5-bit byte address
// Notes: register offsets and field positions are local to this block
package acq_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_MHZ = 25;
    localparam int FILT_TIME_NS = 1000;
    // least time, so round up to whole cycles
    localparam int FILT_CYC = (FILT_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int FILT_W = 5;

    // ------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------
    localparam int NUM_CH = 8;
    localparam int CH_W = 3;
    localparam int SAMPLE_W = 16;
    localparam int BUF_DEPTH = 1024;
    localparam int STAGE_DEPTH = 8;
    localparam int CNT_W = 24;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_CFG = 5'h04;
    localparam logic [ADDR_W-1:0] REG_PERIOD = 5'h08;
    localparam logic [ADDR_W-1:0] REG_COUNT = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h10;
    localparam logic [ADDR_W-1:0] REG_DATA = 5'h14;
    localparam logic [ADDR_W-1:0] REG_LEVEL = 5'h18;

    // control command bits (write only, self clearing)
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int CTRL_CLEAR = 2;

    // configuration fields
    localparam int CFG_START_EXT = 0;
    localparam int CFG_STOP_LO = 1;
    localparam int CFG_CLK_EXT = 3;
    localparam int CFG_START_FALL = 4;
    localparam int CFG_FILT_EN = 7;
    localparam int CFG_RING = 8;
    localparam int CFG_LAST_LO = 9;
    localparam int CFG_W = 12;

    // status bits
    localparam int STS_BUSY = 0;
    localparam int STS_ARMED = 1;
    localparam int STS_DONE = 2;
    localparam int STS_OVERRUN = 3;
    localparam int STS_WRAPPED = 4;
    localparam int STS_EMPTY = 5;
    localparam int STS_FULL = 6;

    // stop source encodings
    localparam logic [1:0] STOP_COUNT = 2'h0;
    localparam logic [1:0] STOP_EXT = 2'h1;
    localparam logic [1:0] STOP_SW = 2'h2;

    // external control input indices
    localparam int IN_START = 0;
    localparam int IN_STOP = 1;
    localparam int IN_CLK = 2;
    localparam int NUM_IN = 3;

    // reset values
    localparam logic [CNT_W-1:0] PERIOD_RST = 24'h0000FA;
    localparam logic [CNT_W-1:0] COUNT_RST = 24'h000400;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARMED = 2'b01,
        ST_RUN = 2'b11,
        ST_CONV = 2'b10
    } seq_state_t;
endpackage

/* File: testbench/conv_model.sv */
// Purpose: converter model answering each conversion start of the sequencer
// Assumes: one result per start, held until accepted
// Notes: slow adds wait cycles; data lines show the inverse of the last word when idle
`timescale 1ns/100ps
`default_nettype none
module conv_model
    import acq_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic conv_start,
    input wire logic [CH_W-1:0] conv_chan,
    output logic conv_valid,
    input wire logic conv_ready,
    output logic [SAMPLE_W-1:0] conv_data
);
    logic [12:0] seq_q;
    logic [3:0] wait_q;
    logic pend_q;

    always @(posedge clk) begin
        if (reset) begin
            conv_valid <= 1'b0;
            pend_q <= 1'b0;
            wait_q <= 4'h0;
            seq_q <= 13'h0000;
            conv_data <= 16'h0000;
        end else if (conv_start) begin
            pend_q <= 1'b1;
            wait_q <= slow ? 4'h5 : 4'h0;
            conv_valid <= 1'b0;
        end else if (pend_q && wait_q != 4'h0) begin
            wait_q <= wait_q - 4'h1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            conv_valid <= 1'b1;
            // channel in the top bits lets the bench check scan order
            conv_data <= {conv_chan, seq_q};
        end else if (conv_valid && conv_ready) begin
            conv_valid <= 1'b0;
            seq_q <= seq_q + 13'h0001;
            conv_data <= ~conv_data;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the acquisition sequencer
// Assumes: buffer cut to 16 words so fill and wrap stay short
// Notes: converter is the partner model; control pins are driven here
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import acq_pkg::*;
    localparam int DEPTH = 16;
    localparam logic [ADDR_W-1:0] RST_A [7] = '{REG_CFG, REG_PERIOD, REG_COUNT,
        REG_STATUS, REG_LEVEL, REG_DATA, 5'h1C};
    localparam logic [31:0] RST_V [7] = '{32'h0, 32'(PERIOD_RST), 32'(COUNT_RST),
        32'h1 << STS_EMPTY, 32'h0, 32'h0, 32'h0};
    logic clk, reset, reg_wr, reg_rd, conv_start, conv_valid, conv_ready, seq_busy;
    logic slow = 1'b0;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic [2:0] pins;
    logic [CH_W-1:0] conv_chan;
    logic [SAMPLE_W-1:0] conv_data;
    int err_count = 0;
    int cmp_count = 0;
    int n_conv = 0;
    int exp_seq = 0;

    acq_sequencer #(.BUF_DEPTH_P(DEPTH), .STAGE_DEPTH_P(STAGE_DEPTH)) i_dut (
        .clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_start(pins[IN_START]), .ext_stop(pins[IN_STOP]), .ext_clk(pins[IN_CLK]),
        .conv_start(conv_start), .conv_chan(conv_chan), .conv_valid(conv_valid),
        .conv_ready(conv_ready), .conv_data(conv_data), .seq_busy(seq_busy));
    conv_model i_conv (.clk(clk), .reset(reset), .slow(slow), .conv_start(conv_start),
        .conv_chan(conv_chan), .conv_valid(conv_valid), .conv_ready(conv_ready),
        .conv_data(conv_data));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            n_conv <= n_conv + 1;
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic conclude();
        if (err_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one idle cycle after each strobe, so no signal is set twice in a step
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] dv);
        reg_addr <= a;
        reg_wdata <= dv;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] dv);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        dv = reg_rdata;
        @(posedge clk);
    endtask

    task automatic drive(input int idx, input logic lvl, input int n);
        pins[idx] <= lvl;
        repeat (n) @(posedge clk);
    endtask

    task automatic wait_idle(input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(negedge clk);
            if (seq_busy === 1'b0) break;
        end
        if (i == lim) begin
            err_count++;
            $display("MISMATCH %0t sequencer stuck busy", $time);
            conclude();
        end
        @(posedge clk);
    endtask

    task automatic run_count(input logic [31:0] cfg, input int per, input int cnt);
        wr(REG_CFG, cfg);
        wr(REG_PERIOD, 32'(per));
        wr(REG_COUNT, 32'(cnt));
        wr(REG_CTRL, 32'h1 << CTRL_START);
        @(posedge clk);
        wait_idle(4000);
    endtask

    task automatic read_back(input int n, input int last);
        for (int k = 0; k < n; k++) begin
            rd(REG_DATA, d);
            check(d, {16'h0000, 3'(k % (last + 1)), 13'(exp_seq)});
            exp_seq++;
        end
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int last, cnt, n, w, filt, c0;
        reset = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        pins = 3'h0;
        void'($urandom(32'h9388EC93));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 7; i++) begin
            rd(RST_A[i], d);
            check(d, RST_V[i]);
        end
        wr(5'h1C, 32'hFFFFFFFF);
        rd(REG_CFG, d);
        check(d, 32'h0);
        // fifo mode stalls when full, ring mode drops the oldest words
        for (int m = 0; m < 2; m++) begin
            run_count(32'(m) << CFG_RING, 1, DEPTH + 4);
            rd(REG_STATUS, d);
            check(32'(d[STS_DONE]), 32'h1);
            check(32'(d[STS_WRAPPED]), 32'(m));
            // period of one paces every cycle, so each scan is overrun
            check(32'(d[STS_OVERRUN]), 32'h1);
            if (m == 0) check(32'(d[STS_FULL]), 32'h1);
            rd(REG_LEVEL, d);
            check(d, 32'(DEPTH));
            exp_seq += 4 * m;
            read_back(m ? DEPTH : DEPTH + 4, 0);
            wr(REG_STATUS, 32'h1C);
        end
        // count mode: count zero means one sample, then random scans
        for (int it = 0; it < 6; it++) begin
            last = it == 0 ? 7 : $urandom % 8;
            cnt = it == 0 ? 0 : 1 + $urandom % 12;
            n = cnt == 0 ? 1 : cnt;
            slow <= 1'(it % 2);
            run_count(32'(last) << CFG_LAST_LO, it == 0 ? 0 : 1 + $urandom % 20, cnt);
            rd(REG_LEVEL, d);
            check(d, 32'(n));
            read_back(n, last);
            rd(REG_STATUS, d);
            check(32'(d[STS_DONE]), 32'h1);
            check(32'(d[STS_EMPTY]), 32'h1);
            wr(REG_STATUS, 32'h1 << STS_DONE);
            rd(REG_STATUS, d);
            check(32'(d[STS_DONE]), 32'h0);
        end
        // external start, clock and stop on every edge choice
        for (int p = 0; p < 8; p++) begin
            filt = $urandom % 2;
            w = filt ? 34 : 6;
            n = 1 + $urandom % 4;
            pins <= 3'(p);
            repeat (30) @(posedge clk);
            wr(REG_CFG, (32'h1 << CFG_START_EXT) | (32'(STOP_EXT) << CFG_STOP_LO)
                | (32'h1 << CFG_CLK_EXT) | (32'(p) << CFG_START_FALL)
                | (32'(filt) << CFG_FILT_EN));
            wr(REG_CTRL, 32'h1 << CTRL_START);
            c0 = n_conv;
            if (filt) begin
                drive(IN_START, ~p[0], 10);
                drive(IN_START, p[0], 30);
            end
            rd(REG_STATUS, d);
            check(32'(d[1:0]), 32'h3);
            drive(IN_START, ~p[0], w);
            rd(REG_STATUS, d);
            check(32'(d[1:0]), 32'h1);
            drive(IN_START, p[0], 30);
            // short clock and stop pulses while running must neither pace nor stop
            if (filt) begin
                drive(IN_CLK, ~p[2], 10);
                drive(IN_CLK, p[2], 30);
                drive(IN_STOP, ~p[1], 10);
                drive(IN_STOP, p[1], 30);
                check(32'(n_conv - c0), 32'h0);
                rd(REG_STATUS, d);
                check(32'(d[1:0]), 32'h1);
            end
            for (int i = 0; i < n; i++) begin
                drive(IN_CLK, ~p[2], w);
                check(32'(n_conv - c0), 32'(i + 1));
                drive(IN_CLK, p[2], 30);
            end
            drive(IN_STOP, ~p[1], w);
            wait_idle(5);
            drive(IN_STOP, p[1], 30);
            rd(REG_STATUS, d);
            check(32'(d[STS_DONE]), 32'h0);
            rd(REG_LEVEL, d);
            check(d, 32'(n));
            exp_seq += n;
            wr(REG_CTRL, 32'h1 << CTRL_CLEAR);
        end
        // timer pacing ended by software
        wr(REG_CFG, 32'(STOP_SW) << CFG_STOP_LO);
        wr(REG_PERIOD, 32'h28);
        wr(REG_CTRL, 32'h1 << CTRL_START);
        c0 = n_conv;
        repeat (200) @(posedge clk);
        check(32'(n_conv - c0 >= 4), 32'h1);
        wr(REG_CTRL, 32'h1 << CTRL_STOP);
        wait_idle(5);
        rd(REG_STATUS, d);
        check(32'(d[STS_DONE]), 32'h0);
        conclude();
    end
endmodule
`default_nettype wire
